// File: design/pdf_defs.vh
// Purpose: constants for the decoded-word packet formatter
// Assumes: 32-bit packets, byte 3 first
// Notes: definitions only
`ifndef PDF_DEFS_VH
`define PDF_DEFS_VH
`define PDF_VTYPE_SHORT_INSTR 3'h1
`define PDF_ITYPE_TEMP_ADDR 3'h0
`define PDF_ITYPE_TEST 3'h7
`define PDF_ROAM_ID 8'h60
`define PDF_ERR_LIMIT 3'h2
`define PDF_NOISE_NONE 2'h0
`define PDF_NOISE_ABANDONED 2'h1
`define PDF_NOISE_DETECTED 2'h2
`define PDF_NOISE_ABSENT 2'h3
`define PDF_ST_IDLE 2'h0
`define PDF_ST_VEC 2'h1
`define PDF_ST_FILL 2'h2
`endif

// File: design/pdf_formatter.v
// Purpose: builds 32-bit vector, message and roaming status packets
// Assumes: decoder inputs come from logic on CLK; host reads via handshake
// Notes: vector and message packets leave on PKT_* with valid/ready, roaming status on ROAM_PKT; no buffering
//
// Contract
// RULE1: short instruction vector packet carries vector type 001 in byte 2.
// RULE2: vector byte 3 is a zero then word position 2 to 87.
// RULE3: vector error flag on over 2 bit errors or failed check.
// RULE4: phase code 0..3 stands for phases a..d.
// RULE5: instruction 000 carries temp address d10..d7, frame d6..d0.
// RULE6: instruction type picks payload meaning; 001-110 reserved, 111 test.
// RULE7: error-free short vector on long address is followed by message packet.
// RULE8: host ignores information bits of that following message packet.
// RULE9: message words sent only after clean vector with message words.
// RULE10: message packet identifier is word position of that message word.
// RULE11: message packet: zero, position, error, phase, 21 information bits.
// RULE12: message error flag set on more than 2 bit errors.
// RULE13: prompt host while any roaming event flag or noise result set.
// RULE14: roaming flags and noise result clear when host reads the packet.
// RULE15: noise result 00 none, 01 abandoned, 10 detected, 11 absent.
// RULE16: lost address word flag raised at most once per frame.
// RULE17: roaming packet id 0x60, events byte 2, noise byte 1, collapse byte 0.
`timescale 1ns/1ps
`include "pdf_defs.vh"

module pdf_formatter (
  input wire CLK,
  input wire SRST,
  // short instruction vector from the decoder
  input wire VEC_VALID,
  input wire [6:0] VEC_WORD_POS,
  input wire [1:0] VEC_PHASE,
  input wire [2:0] VEC_BIT_ERRS,
  input wire VEC_CHECK_FAIL,
  input wire VEC_LONG_ADDR,
  input wire [2:0] VEC_INSTR,
  input wire [10:0] VEC_PAYLOAD,
  output wire VEC_READY,
  // message words from the decoder
  input wire MSG_VALID,
  input wire [6:0] MSG_WORD_POS,
  input wire [1:0] MSG_PHASE,
  input wire [2:0] MSG_BIT_ERRS,
  input wire [20:0] MSG_INFO,
  input wire MSG_PAGE_OK,
  output wire MSG_READY,
  // roaming events, one-cycle pulses
  input wire EV_RESYNC_IGNORED,
  input wire EV_FIRST_SYNC_MISSED,
  input wire EV_FRAME_INFO_LOST,
  input wire EV_SECOND_SYNC_MISSED,
  input wire EV_BLOCK_INFO_LOST,
  input wire EV_ADDR_WORD_LOST,
  input wire EV_NET_BIT_UPDATED,
  input wire EV_NET_BIT_VALUE,
  input wire EV_NOISE_VALID,
  input wire [1:0] EV_NOISE_RESULT,
  input wire EV_COLLAPSE_UPDATED,
  input wire [2:0] EV_RECEIVED_COLLAPSE,
  input wire FRAME_START,
  // roaming status read by host
  input wire ROAM_READ,
  output wire [31:0] ROAM_PKT,
  output wire ROAM_PROMPT,
  // packet output
  output wire PKT_VALID,
  output wire [31:0] PKT_DATA,
  input wire PKT_READY
);

  // -------------------------------------------------------------
  // sequencer states and sizes
  // -------------------------------------------------------------
  localparam [1:0] ST_IDLE = `PDF_ST_IDLE;
  localparam [1:0] ST_VEC = `PDF_ST_VEC;
  localparam [1:0] ST_FILL = `PDF_ST_FILL;
  // sticky roaming event slots; slot 0 is the collapse update
  localparam integer NUM_EV = 8;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [31:0] pkt_q;
  reg [31:0] pkt_d;
  reg [31:0] fill_q;
  reg [31:0] fill_d;

  // -------------------------------------------------------------
  // vector packet assembly
  // -------------------------------------------------------------
  wire vec_err;
  wire [7:0] vec_byte3;
  wire [7:0] vec_byte2;
  wire [7:0] vec_byte1;
  wire [7:0] vec_byte0;
  wire [31:0] vec_pkt;

  // over the limit, or a check that still fails after correction
  assign vec_err = (VEC_BIT_ERRS > `PDF_ERR_LIMIT) | VEC_CHECK_FAIL; // RULE3
  assign vec_byte3 = {1'b0, VEC_WORD_POS}; // RULE2
  // bits 4:3 unused, driven low so the host sees a steady value
  assign vec_byte2 = {vec_err, VEC_PHASE, 2'h0, // RULE4
                      `PDF_VTYPE_SHORT_INSTR}; // RULE1
  // payload passes whole; its meaning is the host's, by type code
  assign vec_byte1 = {2'h0, VEC_PAYLOAD[10:5]}; // RULE5
  assign vec_byte0 = {VEC_PAYLOAD[4:0], VEC_INSTR}; // RULE6
  assign vec_pkt = {vec_byte3, vec_byte2, vec_byte1, vec_byte0};

  // -------------------------------------------------------------
  // trailing message packet after a clean long-address vector
  // -------------------------------------------------------------
  wire need_fill;
  wire [6:0] fill_pos;
  wire [10:0] fill_head;
  wire [31:0] fill_pkt;

  assign need_fill = VEC_LONG_ADDR & ~vec_err; // RULE7
  // word after the vector; wraps in 7 bits, still offered after a vector at 127
  assign fill_pos = VEC_WORD_POS + 7'h01;
  assign fill_head = {1'b0, fill_pos, vec_err, VEC_PHASE};
  // information bits carry nothing, so zeros are sent
  assign fill_pkt = {fill_head, 21'h0}; // RULE8

  // -------------------------------------------------------------
  // message packet assembly
  // -------------------------------------------------------------
  wire msg_err;
  wire msg_take;
  wire [7:0] msg_byte3;
  wire [7:0] msg_byte2;
  wire [15:0] msg_low;
  wire [31:0] msg_pkt;

  assign msg_err = MSG_BIT_ERRS > `PDF_ERR_LIMIT; // RULE12
  assign msg_byte3 = {1'b0, MSG_WORD_POS}; // RULE10
  assign msg_byte2 = {msg_err, MSG_PHASE, MSG_INFO[20:16]}; // RULE11
  assign msg_low = MSG_INFO[15:0]; // RULE11
  assign msg_pkt = {msg_byte3, msg_byte2, msg_low};
  // words of a failed or empty vector are taken and dropped, not held
  assign msg_take = MSG_VALID & MSG_PAGE_OK; // RULE9

  // -------------------------------------------------------------
  // output sequencer
  // -------------------------------------------------------------
  wire out_free;

  assign out_free = (state_q == ST_IDLE);
  assign VEC_READY = out_free;
  // vector first, so a message never splits a vector from its trailer
  assign MSG_READY = out_free & ~VEC_VALID; // RULE9
  assign PKT_VALID = ~out_free;
  assign PKT_DATA = pkt_q;

  always @* begin
    state_d = state_q;
    pkt_d = pkt_q;
    fill_d = fill_q;
    case (state_q)
      ST_IDLE: begin
        if (VEC_VALID) begin
          pkt_d = vec_pkt;
          fill_d = fill_pkt;
          if (need_fill) begin
            state_d = ST_FILL; // RULE7
          end else begin
            state_d = ST_VEC;
          end
        end else if (msg_take) begin // RULE9
          pkt_d = msg_pkt;
          state_d = ST_VEC;
        end
      end
      ST_VEC: begin
        if (PKT_READY) begin
          state_d = ST_IDLE;
        end
      end
      ST_FILL: begin
        // trailer goes out right after the vector packet is taken
        if (PKT_READY) begin
          pkt_d = fill_q; // RULE7
          state_d = ST_VEC;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge CLK) begin
    if (SRST) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // cleared on reset so the bus shows zero until the first packet; later idle cycles keep the last packet
  always @(posedge CLK) begin
    if (SRST) begin
      pkt_q <= 32'h0;
      fill_q <= 32'h0;
    end else begin
      pkt_q <= pkt_d;
      fill_q <= fill_d;
    end
  end

  // -------------------------------------------------------------
  // roaming event sources
  // -------------------------------------------------------------
  reg addr_lost_done_q;
  wire addr_lost_set;
  wire [NUM_EV-1:0] ev_set;
  wire [NUM_EV-1:0] ev_flags;

  // one report per frame; FRAME_START re-arms
  assign addr_lost_set = EV_ADDR_WORD_LOST & ~addr_lost_done_q; // RULE16
  assign ev_set = {EV_RESYNC_IGNORED, EV_FIRST_SYNC_MISSED,
                   EV_FRAME_INFO_LOST, EV_SECOND_SYNC_MISSED,
                   EV_BLOCK_INFO_LOST, addr_lost_set,
                   EV_NET_BIT_UPDATED, EV_COLLAPSE_UPDATED};

  always @(posedge CLK) begin
    if (SRST) begin
      addr_lost_done_q <= 1'b0;
    end else if (FRAME_START) begin
      addr_lost_done_q <= 1'b0; // RULE16
    end else if (EV_ADDR_WORD_LOST) begin
      addr_lost_done_q <= 1'b1; // RULE16
    end
  end

  // -------------------------------------------------------------
  // sticky event flags
  // -------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EV; gi = gi + 1) begin : g_flag
      reg flag_q;
      // a new event in the read cycle survives the clear
      always @(posedge CLK) begin
        if (SRST) begin
          flag_q <= 1'b0;
        end else if (ev_set[gi]) begin
          flag_q <= 1'b1;
        end else if (ROAM_READ) begin
          flag_q <= 1'b0; // RULE14
        end
      end
      assign ev_flags[gi] = flag_q;
    end
  endgenerate

  // -------------------------------------------------------------
  // values carried with the events
  // -------------------------------------------------------------
  reg net_bit_value_q;
  reg [1:0] noise_result_q;
  reg [2:0] received_collapse_q;

  // net bit and collapse values survive a read; only their flags are cleared
  always @(posedge CLK) begin
    if (SRST) begin
      net_bit_value_q <= 1'b0;
    end else if (EV_NET_BIT_UPDATED) begin
      net_bit_value_q <= EV_NET_BIT_VALUE;
    end
  end

  // a fresh result in the read cycle wins over the clear
  always @(posedge CLK) begin
    if (SRST) begin
      noise_result_q <= `PDF_NOISE_NONE;
    end else if (EV_NOISE_VALID) begin
      noise_result_q <= EV_NOISE_RESULT; // RULE15
    end else if (ROAM_READ) begin
      noise_result_q <= `PDF_NOISE_NONE; // RULE14
    end
  end

  always @(posedge CLK) begin
    if (SRST) begin
      received_collapse_q <= 3'h0;
    end else if (EV_COLLAPSE_UPDATED) begin
      received_collapse_q <= EV_RECEIVED_COLLAPSE;
    end
  end

  // -------------------------------------------------------------
  // roaming status packet and host prompt
  // -------------------------------------------------------------
  wire [7:0] roam_byte2;
  wire [7:0] roam_byte1;
  wire [7:0] roam_byte0;

  assign roam_byte2 = {ev_flags[7:1], net_bit_value_q};
  // unused bits read as zero
  assign roam_byte1 = {6'h0, noise_result_q}; // RULE15
  assign roam_byte0 = {4'h0, ev_flags[0], received_collapse_q};
  assign ROAM_PKT = {`PDF_ROAM_ID, roam_byte2, roam_byte1, // RULE17
                     roam_byte0};
  // level prompt: stays up until a read clears every source
  assign ROAM_PROMPT = (|ev_flags) | (|noise_result_q); // RULE13

endmodule

// File: verification/pdf_formatter_monitor.sv
// Purpose: port assertions for pdf_formatter
// Assumes: SRST synchronous, active high
// Notes: bound to every pdf_formatter
`timescale 1ns/1ps
module pdf_formatter_monitor (
  input logic CLK, SRST, VEC_VALID, VEC_READY, VEC_CHECK_FAIL,
  input logic VEC_LONG_ADDR, MSG_VALID, MSG_READY, MSG_PAGE_OK,
  input logic ROAM_READ, ROAM_PROMPT, PKT_VALID, PKT_READY, EV_NOISE_VALID,
  input logic [1:0] VEC_PHASE, MSG_PHASE,
  input logic [2:0] VEC_BIT_ERRS, MSG_BIT_ERRS, VEC_INSTR,
  input logic [6:0] VEC_WORD_POS, MSG_WORD_POS,
  input logic [10:0] VEC_PAYLOAD,
  input logic [20:0] MSG_INFO,
  input logic [31:0] ROAM_PKT, PKT_DATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  wire vt = VEC_VALID && VEC_READY;
  wire ve = VEC_BIT_ERRS > 3'h2 || VEC_CHECK_FAIL;
  wire mt = MSG_VALID && MSG_READY && MSG_PAGE_OK;
  property p_vtype; vt |=> PKT_VALID && PKT_DATA[18:16] == 3'h1; endproperty
  a_vtype: assert property (p_vtype) else $error("vec type");
  property p_vhead; vt |=> PKT_DATA[31:21] ==
    {1'b0, $past(VEC_WORD_POS), $past(ve), $past(VEC_PHASE)}; endproperty
  a_vhead: assert property (p_vhead) else $error("vec head");
  property p_vbody; vt |=> PKT_DATA[13:0] ==
    {$past(VEC_PAYLOAD), $past(VEC_INSTR)}; endproperty
  a_vbody: assert property (p_vbody) else $error("vec body");
  property p_fill; vt && VEC_LONG_ADDR && !ve ##1 PKT_READY |=>
    PKT_VALID && !PKT_DATA[23] && PKT_DATA[20:0] == 21'h0; endproperty
  a_fill: assert property (p_fill) else $error("no fill");
  property p_msg; mt |=> PKT_VALID && PKT_DATA == {1'b0, $past(MSG_WORD_POS),
    $past(MSG_BIT_ERRS) > 3'h2, $past(MSG_PHASE), $past(MSG_INFO)}; endproperty
  a_msg: assert property (p_msg) else $error("msg pkt");
  property p_prompt; ROAM_PROMPT ==
    (|ROAM_PKT[23:17] || |ROAM_PKT[9:8] || ROAM_PKT[3]); endproperty
  a_prompt: assert property (p_prompt) else $error("prompt");
  property p_nclr; ROAM_READ && !EV_NOISE_VALID |=> ROAM_PKT[9:8] == 2'h0;
  endproperty
  a_nclr: assert property (p_nclr) else $error("noise kept");
  property p_id; ROAM_PKT[31:24] == 8'h60; endproperty
  a_id: assert property (p_id) else $error("roam id");
endmodule
bind pdf_formatter pdf_formatter_monitor pdf_formatter_monitor_inst (.*);

// File: verification/pdf_formatter_tb.sv
// Purpose: self-checking bench for pdf_formatter
// Assumes: host model acks packets and stalls on request
// Notes: fill packet info bits carry nothing for the host
`timescale 1ns/1ps
module pdf_formatter_tb;
  logic CLK = 0, SRST = 1, VEC_VALID = 0, VEC_CHECK_FAIL = 0;
  logic VEC_LONG_ADDR = 0, MSG_VALID = 0, MSG_PAGE_OK = 0, ROAM_READ = 0;
  logic [1:0] VEC_PHASE = 0, MSG_PHASE = 0;
  logic [2:0] VEC_BIT_ERRS = 0, MSG_BIT_ERRS = 0, VEC_INSTR = 0;
  logic [6:0] VEC_WORD_POS = 0, MSG_WORD_POS = 0;
  logic [10:0] VEC_PAYLOAD = 0;
  logic [20:0] MSG_INFO = 0;
  logic [15:0] evv = 0;
  logic stall = 0, VEC_READY, MSG_READY, ROAM_PROMPT, PKT_VALID, PKT_READY, got;
  logic [31:0] ROAM_PKT, PKT_DATA, pkt;
  wire EV_RESYNC_IGNORED, EV_FIRST_SYNC_MISSED, EV_FRAME_INFO_LOST;
  wire EV_SECOND_SYNC_MISSED, EV_BLOCK_INFO_LOST, EV_ADDR_WORD_LOST;
  wire EV_NET_BIT_UPDATED, EV_NET_BIT_VALUE, EV_NOISE_VALID;
  wire EV_COLLAPSE_UPDATED, FRAME_START;
  wire [1:0] EV_NOISE_RESULT;
  wire [2:0] EV_RECEIVED_COLLAPSE;
  int failures = 0, num_checks = 0, cyc = 0;
  assign {FRAME_START, EV_RESYNC_IGNORED, EV_FIRST_SYNC_MISSED,
    EV_FRAME_INFO_LOST, EV_SECOND_SYNC_MISSED, EV_BLOCK_INFO_LOST,
    EV_ADDR_WORD_LOST, EV_NET_BIT_UPDATED, EV_NET_BIT_VALUE, EV_NOISE_VALID,
    EV_NOISE_RESULT, EV_COLLAPSE_UPDATED, EV_RECEIVED_COLLAPSE} = evv;
  pdf_formatter pdf_formatter_inst (.*);
  pdf_host_model pdf_host_model_inst (.clk(CLK), .srst(SRST),
    .pkt_valid(PKT_VALID), .stall(stall), .pkt_data(PKT_DATA),
    .pkt_ready(PKT_READY), .got(got), .pkt(pkt));
  initial forever #2 CLK = ~CLK;
  task tally_and_finish;
    if (failures == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge CLK) if (++cyc == 3000) begin
    failures++;
    tally_and_finish();
  end
  task chk(input [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // release any stall after one edge; packet must stand meanwhile
  task getp(input [31:0] e);
    int n;
    n = 0;
    @(posedge CLK);
    stall <= 0;
    while (got !== 1'b1 && n < 20) begin
      n++;
      @(posedge CLK);
    end
    chk(got === 1'b1 ? pkt : ~e, e);
  endtask
  task vec(input [6:0] p, input [1:0] ph, input [2:0] er, input cf, lg,
    input [2:0] it, input [10:0] d);
    @(posedge CLK);
    VEC_VALID <= 1;
    {VEC_WORD_POS, VEC_PHASE, VEC_BIT_ERRS, VEC_CHECK_FAIL, VEC_LONG_ADDR,
      VEC_INSTR, VEC_PAYLOAD} <= {p, ph, er, cf, lg, it, d};
    @(posedge CLK);
    while (!VEC_READY) @(posedge CLK);
    VEC_VALID <= 0;
    getp({1'b0, p, er > 3'h2 || cf, ph, 5'h01, 2'h0, d, it});
    if (lg && er < 3'h3 && !cf)
      getp({1'b0, p + 7'h01, 1'b0, ph, 21'h0});
  endtask
  task msg(input [6:0] p, input [1:0] ph, input [2:0] er, input [20:0] d,
    input ok);
    @(posedge CLK);
    MSG_VALID <= 1;
    {MSG_WORD_POS, MSG_PHASE, MSG_BIT_ERRS, MSG_INFO, MSG_PAGE_OK} <=
      {p, ph, er, d, ok};
    @(posedge CLK);
    while (!MSG_READY) @(posedge CLK);
    MSG_VALID <= 0;
  endtask
  task roam(input [15:0] v, input [31:0] e);
    @(posedge CLK);
    evv <= v;
    @(posedge CLK);
    evv <= 16'h0000;
    @(posedge CLK);
    chk(ROAM_PKT, e);
    chk({31'h0, ROAM_PROMPT}, {31'h0, |e[23:17] || |e[9:8] || e[3]});
    ROAM_READ <= 1;
    @(posedge CLK);
    ROAM_READ <= 0;
    @(posedge CLK);
    chk(ROAM_PKT & 32'hFFFEFFF8, 32'h60000000);
  endtask
  initial begin
    repeat (5) @(posedge CLK);
    SRST <= 0;
    roam(16'h8000, 32'h60000000);
    for (int i = 0; i < 8; i++) begin
      stall <= i[2] && i[0];
      vec(i == 7 ? 7'h57 : 7'h02 + i[6:0], i[1:0], i == 2 ? 3'h3 : 3'h2,
        i == 6, i[1], i[2:0], 11'h5A5 ^ i[10:0]);
    end
    msg(7'h09, 2'h0, 3'h0, 21'h000001, 1'b0);
    msg(7'h57, 2'h3, 3'h3, 21'h1F0F0F, 1'b1);
    getp({8'h57, 3'h7, 21'h1F0F0F});
    msg(7'h03, 2'h2, 3'h2, 21'h0A5A5A, 1'b1);
    getp({8'h03, 3'h2, 21'h0A5A5A});
    for (int i = 8; i < 15; i++) roam(16'h1 << i, {8'h60, 8'h1 << (i - 7),
      16'h0});
    roam(16'h0200, 32'h60000000);
    roam(16'h8000, 32'h60000000);
    roam(16'h0200, 32'h60040000);
    roam(16'h0180, 32'h60030000);
    for (int c = 0; c < 4; c++) roam({10'h1, c[1:0], 4'h0}, {16'h6001, 6'h0,
      c[1:0], 8'h0});
    roam(16'h000D, 32'h6001000D);
    tally_and_finish();
  end
endmodule

// File: verification/pdf_host_model.sv
// Purpose: host side that takes packets from pdf_formatter
// Assumes: ready is registered, so a stall lands one edge late
// Notes: stall holds ready low to make packets stand
`timescale 1ns/1ps
module pdf_host_model (
  input logic clk,
  input logic srst,
  input logic pkt_valid,
  input logic stall,
  input logic [31:0] pkt_data,
  output logic pkt_ready,
  output logic got,
  output logic [31:0] pkt
);
  always @(posedge clk) begin
    pkt_ready <= !srst && !stall;
    got <= !srst && pkt_valid && pkt_ready;
    pkt <= pkt_data;
  end
endmodule
